// file: logic/prt_pkg.sv
`default_nettype none
package prt_pkg;
   localparam int CNT_W = 16;
   localparam int NUM_W = 25;
   localparam int CLK_PERIOD_NS = 20;
   localparam int TICK_NS = 1000;
   localparam int TICK_DIV = TICK_NS / CLK_PERIOD_NS;
   localparam logic [5:0] TICK_LAST = 6'(TICK_DIV - 1);
   localparam logic [5:0] TICK_ZERO = 6'h00;
   localparam int PHASE_MAX_MS = 32;
   localparam logic [CNT_W-1:0] PHASE_MAX_TICKS =
      CNT_W'(PHASE_MAX_MS * 1000000 / TICK_NS);
   localparam logic [15:0] OFFSET_C = 16'h00eb;
   localparam logic [15:0] SLOPE_C = 16'h0190;
   localparam logic [4:0] DIV_LAST = 5'(NUM_W - 1);
   localparam logic [4:0] DIV_ZERO = 5'h00;

   typedef enum logic [2:0] {
      ST_IDLE, ST_WAIT_LO, ST_WAIT_HI, ST_HIGH, ST_LOW, ST_DIVIDE
   } prt_state_type;
endpackage
`default_nettype wire

// file: logic/prt_cnt_if.sv
`timescale 1ns/100ps
`default_nettype none
interface prt_cnt_if #(parameter int W = 16) ();
   logic clr;
   logic run;
   logic tick;
   logic [W-1:0] count;
   logic sat;
   modport ctl (output clr, output run, output tick,
                input count, input sat);
   modport cnt (input clr, input run, input tick,
                output count, output sat);
endinterface
`default_nettype wire

// file: logic/prt_phase_counter.sv
`timescale 1ns/100ps
`default_nettype none
module prt_phase_counter #(
   parameter int W = 16
) (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   prt_cnt_if.cnt cnt_io
);
   logic [W-1:0] count_q;

   // counts ticks while running, sticks at all ones
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         count_q <= '0;
      end else if (cnt_io.clr) begin
         count_q <= '0;
      end else if (cnt_io.run && cnt_io.tick && !cnt_io.sat) begin
         count_q <= count_q + 1'b1;
      end
   end

   assign cnt_io.count = count_q;
   assign cnt_io.sat = &count_q;
endmodule
`default_nettype wire

// file: logic/prt_reader.sv
// Function
// - time high and low phases, derive temperature
// - ratio only; stable fast counting clock
// - single sensor input line carries everything
// - clear both counters before each measurement
// - each phase counter sixteen bits wide
// - wait for low, then rising edge
// - high counter runs; falling edge swaps counters
// - low counter stops at next rising edge
// - hold both counts readable after completion
// - counter tick one microsecond or finer
// - path must keep high/low ratio intact
// - celsius equals offset minus slope times ratio
`timescale 1ns/100ps
`default_nettype none
module prt_reader #(
   parameter int CW = prt_pkg::CNT_W,
   parameter logic [15:0] OFFSET = prt_pkg::OFFSET_C,
   parameter logic [15:0] SLOPE = prt_pkg::SLOPE_C
) (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic sense_i,
   input wire logic start_i,
   output logic busy_o,
   output logic done_o,
   output logic error_o,
   output logic timeout_o,
   output logic [CW-1:0] high_phase_time_o,
   output logic [CW-1:0] low_phase_time_o,
   output logic [15:0] temp_c_o
);
   import prt_pkg::*;

   localparam int DONE_WAIT = 30;

   prt_state_type state_q;
   logic s1_q, s2_q, s3_q;
   logic rise, fall;
   logic [5:0] tick_cnt_q;
   logic tick;
   logic take;
   logic [CW-1:0] hi_q, lo_q;
   logic [NUM_W-1:0] num_q, quo_q;
   logic [CW:0] rem_q, rem_sh, diff;
   logic [4:0] step_q;
   logic [31:0] prod;
   logic div_end;
   logic [2:0] fill_q;
   logic sync_ok;
   logic [NUM_W-1:0] quo_next;

   prt_cnt_if #(.W(CW)) hi_if ();
   prt_cnt_if #(.W(CW)) lo_if ();

   prt_phase_counter #(.W(CW)) u_hi_cnt (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .cnt_io(hi_if.cnt)
   );
   prt_phase_counter #(.W(CW)) u_lo_cnt (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .cnt_io(lo_if.cnt)
   );

   // one input pin, synchronised before any edge logic
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         fill_q <= 3'h0;
      end else begin
         s1_q <= sense_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         fill_q <= {fill_q[1:0], 1'b1};
      end
   end
   // no edge or level is trusted until the chain holds real pin samples
   assign sync_ok = fill_q[2];
   // both edges see the same delay, so the duty ratio is kept
   assign rise = sync_ok && s2_q && !s3_q;
   assign fall = sync_ok && !s2_q && s3_q;

   // 1 us counting tick from the system clock
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         tick_cnt_q <= TICK_ZERO;
      end else if (tick) begin
         tick_cnt_q <= TICK_ZERO;
      end else begin
         tick_cnt_q <= tick_cnt_q + 1'b1;
      end
   end
   assign tick = (tick_cnt_q == TICK_LAST);

   assign take = (state_q == ST_IDLE) && start_i;
   assign hi_if.clr = take;
   assign lo_if.clr = take;
   assign hi_if.tick = tick;
   assign lo_if.tick = tick;
   assign hi_if.run = (state_q == ST_HIGH);
   assign lo_if.run = (state_q == ST_LOW);
   assign div_end = (state_q == ST_DIVIDE) && (step_q == DIV_ZERO);

   // measurement sequence
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_q <= ST_IDLE;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (start_i) begin
                  state_q <= ST_WAIT_LO;
               end
            end
            ST_WAIT_LO: begin
               if (sync_ok && !s2_q) begin
                  state_q <= ST_WAIT_HI;
               end
            end
            ST_WAIT_HI: begin
               if (rise) begin
                  state_q <= ST_HIGH;
               end
            end
            ST_HIGH: begin
               if (hi_if.sat) begin
                  state_q <= ST_IDLE;
               end else if (fall) begin
                  state_q <= ST_LOW;
               end
            end
            ST_LOW: begin
               if (lo_if.sat) begin
                  state_q <= ST_IDLE;
               end else if (rise) begin
                  state_q <= ST_DIVIDE;
               end
            end
            ST_DIVIDE: begin
               if (step_q == DIV_ZERO) begin
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // counts latched at the closing edge and held
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         hi_q <= '0;
         lo_q <= '0;
      end else if (state_q == ST_LOW && rise && !lo_if.sat) begin
         hi_q <= hi_if.count;
         lo_q <= lo_if.count;
      end
   end
   assign high_phase_time_o = hi_q;
   assign low_phase_time_o = lo_q;

   // restoring divide of slope*high by low
   assign prod = 32'(SLOPE) * 32'(hi_q);
   assign rem_sh = {rem_q[CW-1:0], num_q[NUM_W-1]};
   assign diff = rem_sh - {1'b0, lo_q};
   // quotient including the bit decided in the current step
   assign quo_next = {quo_q[NUM_W-2:0], (rem_sh >= {1'b0, lo_q})};

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         step_q <= DIV_ZERO;
         num_q <= '0;
         quo_q <= '0;
         rem_q <= '0;
      end else if (state_q == ST_LOW && rise) begin
         step_q <= DIV_LAST;
         rem_q <= '0;
         quo_q <= '0;
      end else if (state_q == ST_DIVIDE) begin
         num_q <= (step_q == DIV_LAST) ? {prod[NUM_W-2:0], 1'b0}
                                       : {num_q[NUM_W-2:0], 1'b0};
         if (step_q == DIV_LAST) begin
            rem_q <= ({{CW{1'b0}}, prod[NUM_W-1]} >= {1'b0, lo_q}) ?
                     {{CW{1'b0}}, prod[NUM_W-1]} - {1'b0, lo_q} :
                     {{CW{1'b0}}, prod[NUM_W-1]};
            quo_q <= {{(NUM_W-1){1'b0}},
                      ({{CW{1'b0}}, prod[NUM_W-1]} >= {1'b0, lo_q})};
         end else begin
            rem_q <= (rem_sh >= {1'b0, lo_q}) ? diff : rem_sh;
            quo_q <= quo_next;
         end
         step_q <= step_q - 1'b1;
      end
   end

   // offset minus slope*ratio, whole degrees
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         temp_c_o <= '0;
      end else if (div_end) begin
         temp_c_o <= OFFSET - quo_next[15:0];
      end
   end

   // status flags, cleared when a measurement is taken
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         done_o <= 1'b0;
         error_o <= 1'b0;
         timeout_o <= 1'b0;
      end else begin
         if (div_end) begin
            done_o <= 1'b1;
         end else if (take) begin
            done_o <= 1'b0;
         end
         if ((hi_if.run && hi_if.sat) || (lo_if.run && lo_if.sat) ||
             (div_end && (lo_q == '0 || quo_next[NUM_W-1:15] != '0))) begin
            error_o <= 1'b1;
         end else if (take) begin
            error_o <= 1'b0;
         end
         if ((hi_if.run && hi_if.count > PHASE_MAX_TICKS) ||
             (lo_if.run && lo_if.count > PHASE_MAX_TICKS)) begin
            timeout_o <= 1'b1;
         end else if (take) begin
            timeout_o <= 1'b0;
         end
      end
   end
   assign busy_o = (state_q != ST_IDLE);

   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);

   sequence seq_close;
      (state_q == ST_LOW) && rise && !lo_if.sat;
   endsequence
   sequence seq_start;
      (state_q == ST_IDLE) && start_i;
   endsequence

   chk_clear_counters: assert property (
      seq_start |=> hi_if.count == '0 && lo_if.count == '0)
      else $error("counters not cleared at start");
   chk_start_flags: assert property (
      seq_start |=> !done_o && !error_o && !timeout_o)
      else $error("flags not cleared at start");
   chk_high_counts: assert property (
      (state_q == ST_HIGH) && tick && !hi_if.sat && !fall
      |=> hi_if.count == $past(hi_if.count) + 1'b1)
      else $error("high counter did not advance");
   chk_low_idle_high: assert property (
      (state_q == ST_HIGH) |=> $stable(lo_if.count))
      else $error("low counter moved in high phase");
   chk_wait_rise: assert property (
      (state_q == ST_WAIT_HI) && !rise |=> state_q != ST_HIGH)
      else $error("high phase entered without rising edge");
   chk_done_after: assert property (
      seq_close ##1 (state_q == ST_DIVIDE) |-> ##[1:DONE_WAIT] done_o)
      else $error("done not raised after measurement");
   chk_hold_counts: assert property (
      done_o && !busy_o |=> $stable(high_phase_time_o)
                           && $stable(low_phase_time_o))
      else $error("results changed while held");
   chk_err_sat: assert property (
      hi_if.run && hi_if.sat |=> error_o && state_q == ST_IDLE)
      else $error("saturation not flagged");
   chk_sync_edge: assert property (
      rise |-> $past(sense_i, 2) && !$past(sense_i, 3))
      else $error("edge not two stages behind pin");
   chk_tick_gap: assert property (
      tick |=> !tick [*8])
      else $error("tick faster than expected");
endmodule
`default_nettype wire

// file: verif/prt_sensor_model.sv
`timescale 1ns/100ps
`default_nettype none
module prt_sensor_model (
   input wire logic run_i,
   input wire logic [31:0] high_ns_i,
   input wire logic [31:0] low_ns_i,
   output logic sense_o
);
   localparam logic [31:0] PHASE_CAP_NS = 32'd32000000;
   // free-running output; each phase length is taken as the phase begins
   initial begin
      sense_o = 1'b0;
      forever begin
         wait (run_i);
         sense_o = 1'b1;
         #(high_ns_i > PHASE_CAP_NS ? PHASE_CAP_NS : high_ns_i);
         sense_o = 1'b0;
         #(low_ns_i > PHASE_CAP_NS ? PHASE_CAP_NS : low_ns_i);
      end
   end
endmodule
`default_nettype wire

// file: verif/test_pulse_ratio_temp_reader.sv
`timescale 1ns/100ps
`default_nettype none
module test_pulse_ratio_temp_reader;
   import prt_pkg::*;
   logic clk_sys_i = 1'b0;
   logic nrst_i = 1'b0;
   logic start_i = 1'b0;
   logic run = 1'b1;
   logic [31:0] hi_ns = 32'd30000;
   logic [31:0] lo_ns = 32'd60000;
   wire logic sense;
   logic busy, done, err, tout;
   logic [15:0] hcnt, lcnt, temp;
   logic n_start = 1'b0;
   logic n_busy, n_done, n_err, n_tout;
   logic [7:0] n_hcnt, n_lcnt;
   logic [15:0] n_temp;
   int fail_count = 0;
   int comparisons = 0;

   always #10 clk_sys_i = ~clk_sys_i;

   prt_sensor_model sensor (.run_i(run), .high_ns_i(hi_ns),
      .low_ns_i(lo_ns), .sense_o(sense));
   prt_reader dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
      .sense_i(sense), .start_i(start_i), .busy_o(busy), .done_o(done),
      .error_o(err), .timeout_o(tout), .high_phase_time_o(hcnt),
      .low_phase_time_o(lcnt), .temp_c_o(temp));
   // narrow counters saturate within a short run
   prt_reader #(.CW(8)) dut_narrow (.clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i), .sense_i(sense), .start_i(n_start),
      .busy_o(n_busy), .done_o(n_done), .error_o(n_err),
      .timeout_o(n_tout), .high_phase_time_o(n_hcnt),
      .low_phase_time_o(n_lcnt), .temp_c_o(n_temp));

   task automatic tick(int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask

   task automatic check_bit(string name, logic exp, logic seen);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %b seen %b", name, exp, seen);
      end
   endtask

   task automatic check_word(string name, int lo, int hi, logic [15:0] seen);
      int v;
      v = $signed(seen);
      comparisons++;
      if ($isunknown(seen) || v < lo || v > hi) begin
         fail_count++;
         $display("[ERR] %s expected %0d..%0d seen %0d", name, lo, hi, v);
      end
   endtask

   task automatic check_flags(logic b, logic d);
      check_bit("busy_o", b, busy);
      check_bit("done_o", d, done);
      check_bit("error_o", 1'b0, err);
      check_bit("timeout_o", 1'b0, tout);
   endtask

   // counts may be one tick off either way, so bound temp over all corners
   task automatic check_result(int h, int l);
      int tmin, tmax, t;
      tmin = 32767;
      tmax = -32768;
      for (int a = h - 1; a <= h + 1; a++) begin
         for (int b = l - 1; b <= l + 1; b++) begin
            t = int'(OFFSET_C) - int'(SLOPE_C) * a / b;
            if (t < tmin) tmin = t;
            if (t > tmax) tmax = t;
         end
      end
      check_word("high_phase_time_o", h - 1, h + 1, hcnt);
      check_word("low_phase_time_o", l - 1, l + 1, lcnt);
      check_word("temp_c_o", tmin, tmax, temp);
   endtask

   task automatic measure(int h, int l, bit poke);
      int n;
      start_i = 1'b1;
      tick(1);
      start_i = 1'b0;
      check_flags(1'b1, 1'b0);
      if (poke) begin
         tick(200);
         start_i = 1'b1;
         tick(1);
         start_i = 1'b0;
      end
      n = 0;
      while (done !== 1'b1 && n < 15000) begin
         tick(1);
         n++;
      end
      check_flags(1'b0, 1'b1);
      check_result(h, l);
      tick(100);
      check_flags(1'b0, 1'b1);
      check_result(h, l);
   endtask

   task automatic test_reset;
      check_flags(1'b0, 1'b0);
      check_word("high_phase_time_o", 0, 0, hcnt);
      check_word("low_phase_time_o", 0, 0, lcnt);
      check_word("temp_c_o", 0, 0, temp);
      $display("test_reset finished");
   endtask

   task automatic test_basic;
      measure(30, 60, 1'b0);
      $display("test_basic finished");
   endtask

   // start lands inside a high phase; a start while busy is ignored
   task automatic test_mid_high;
      hi_ns = 32'd35000;
      lo_ns = 32'd65000;
      @(posedge sense);
      tick(50);
      measure(35, 65, 1'b1);
      $display("test_mid_high finished");
   endtask

   // shorter high phase right after a longer one shows counters restart
   task automatic test_back_to_back;
      hi_ns = 32'd20000;
      lo_ns = 32'd90000;
      measure(20, 90, 1'b0);
      $display("test_back_to_back finished");
   endtask

   // a long high phase saturates the narrow counter: error, no done
   task automatic test_broken_line;
      int n;
      hi_ns = 32'd300000;
      lo_ns = 32'd60000;
      n_start = 1'b1;
      tick(1);
      n_start = 1'b0;
      check_bit("narrow busy_o", 1'b1, n_busy);
      n = 0;
      while (n_busy === 1'b1 && n < 20000) begin
         tick(1);
         n++;
      end
      check_bit("narrow busy_o", 1'b0, n_busy);
      check_bit("narrow error_o", 1'b1, n_err);
      check_bit("narrow done_o", 1'b0, n_done);
      check_bit("narrow timeout_o", 1'b0, n_tout);
      $display("test_broken_line finished");
   endtask

   task automatic stop_test;
      $display("checks %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      tick(3);
      nrst_i = 1'b1;
      test_reset();
      test_basic();
      test_mid_high();
      test_back_to_back();
      test_broken_line();
      stop_test();
   end

   initial begin
      #1500000;
      fail_count++;
      $display("[ERR] watchdog expected finish seen hang");
      stop_test();
   end
endmodule
`default_nettype wire
